// File: tb_tlbst_top.sv
// Self-checking testbench for the entry staging block
`timescale 1ns/1ps
module tb_tlbst_top
  import tlbst_pkg::*;
();
  // ********
  // Stimulus and observed signals
  // ********
  logic clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, kern = 1'b1, ext = 1'b1;
  logic ew = 1'b0, er = 1'b0, go = 1'b0, ar = 1'b0, ast = 1'b0, aunc = 1'b0;
  logic [4:0]  sel = '0;    // Register select
  logic [63:0] wd = '0;     // Write data
  logic [63:0] va = '0;     // Miss address handed to the model
  logic [5:0]  idx = '0;    // Array index
  logic [27:0] fsup = '0;   // Frame suppress bits
  logic [39:0] aaddr = '0;  // Access address
  logic [11:0] pat;         // Mask pattern
  tlbst_lo_s   alo = '0;    // Access page attributes
  logic [63:0] rdq, bus, mva;
  logic        done, hil, lf, sf, mf, bv, mien;
  logic [30:0] hpp;
  logic [7:0]  hsi, msi;
  int          mismatches = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  tlbst_far_model i_tlbst_far_model (.clk(clk), .go(go), .va(va), .miss_en(mien),
    .miss_vaddr(mva), .miss_space_identifier(msi));
  tlbst_top i_tlbst_top (.clk(clk), .sys_rst(sys_rst), .cop_wr_en(wr_en), .cop_rd_en(rd_en),
    .cop_sel(sel), .cop_wdata(wd), .cop_rdata_q(rdq), .kernel_mode(kern), .ext64_en(ext),
    .entry_index(idx), .entry_write_en(ew), .entry_read_en(er), .entry_read_done_q(done),
    .frame_suppress_reg(fsup), .miss_en(mien), .miss_vaddr(mva), .miss_space_identifier(msi),
    .hi_load_q(hil), .hi_page_pair_q(hpp), .hi_space_identifier_q(hsi), .acc_req(ar),
    .acc_store(ast), .acc_uncached(aunc), .acc_addr(aaddr), .acc_lo(alo),
    .load_xlate_fault_q(lf), .store_xlate_fault_q(sf), .modify_fault_q(mf),
    .bus_addr_valid_q(bv), .system_bus_lines_q(bus));
  // ********
  // Access tasks
  // ********
  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Strobe held for exactly one sampling edge
  task automatic wr(logic [4:0] s, logic [63:0] d);
    @(posedge clk);
    sel <= s;
    wd <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // Data lands one cycle after the strobe
  task automatic rd(logic [4:0] s, logic [63:0] e);
    @(posedge clk);
    sel <= s;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 check("cop_rdata_q", rdq, e);
  endtask : rd
  // One-cycle entry read or entry write pulse
  task automatic op(bit is_rd);
    @(posedge clk);
    if (is_rd) er <= 1'b1;
    else ew <= 1'b1;
    @(posedge clk);
    er <= 1'b0;
    ew <= 1'b0;
  endtask : op
  // Access request; verdict flags expected one cycle later
  task automatic acc(logic st, logic un, logic d, logic v, logic [3:0] e);
    @(posedge clk);
    ar <= 1'b1;
    ast <= st;
    aunc <= un;
    alo <= tlbst_lo_s'{2'b10, 28'h000_0000, 3'h0, d, v};
    @(posedge clk);
    ar <= 1'b0;
    #1 check("fault_flags", {60'h0, lf, sf, mf, bv}, {60'h0, e});
  endtask : acc
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // ********
  // Test sequence
  // ********
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(5'h02, 64'h0000_0000_0000_0000);
    wr(5'h02, '1);
    rd(5'h02, 64'hC000_0003_FFFF_FFFF);
    wr(5'h01, '1);
    rd(5'h02, 64'hC000_0003_FFFF_FFFF);
    kern <= 1'b0;
    ext <= 1'b0;
    wr(5'h03, 64'h0000_0000_8000_0047);
    rd(5'h03, 64'hFFFF_FFFF_8000_0047);
    kern <= 1'b1;
    rd(5'h03, 64'h0000_0003_8000_0047);
    ext <= 1'b1;
    wr(5'h04, '1);
    rd(5'h04, 64'hFFFF_FFFF_FF80_0000);
    va <= 64'h0000_0ABC_DEF1_2000;
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    @(posedge clk);
    #1 check("hi_load_q", {63'h0, hil}, 64'h1);
    check("hi_page_pair_q", {33'h0, hpp}, {33'h0, va[43:13]});
    check("hi_space_identifier_q", {56'h0, hsi}, 64'h5A);
    rd(5'h04, {{41{1'b1}}, va[31:13], 4'h0});
    for (int k = 0; k < 7; k++) begin
      pat = 12'((1 << (2 * k)) - 1);
      wr(5'h05, {39'h0, pat, 13'h0} | 64'hFFFF_FFFF_FE00_1FFF);
      rd(5'h05, {39'h0, pat, 13'h0});
    end
    // Pair written at the top index, zeros at index 0, then read back
    wr(5'h02, '1);
    wr(5'h03, 64'h4000_0000_0000_0046);
    wr(5'h05, 64'h0000_0000_0000_6000);
    fsup <= 28'h000_000F;
    idx <= 6'h3F;
    op(1'b0);
    wr(5'h02, '0);
    wr(5'h03, '0);
    wr(5'h05, '0);
    idx <= 6'h00;
    op(1'b0);
    idx <= 6'h3F;
    op(1'b1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    check("entry_read_done_q", {63'h0, done}, 64'h1);
    rd(5'h02, 64'hC000_0003_FFFF_FC3E);
    rd(5'h03, 64'h4000_0000_0000_0006);
    rd(5'h05, 64'h0000_0000_0000_6000);
    aaddr <= 40'h12_3456_7890;
    acc(1'b0, 1'b0, 1'b1, 1'b0, 4'b1000);
    acc(1'b1, 1'b0, 1'b1, 1'b0, 4'b0100);
    acc(1'b1, 1'b0, 1'b0, 1'b1, 4'b0010);
    acc(1'b1, 1'b0, 1'b1, 1'b1, 4'b0001);
    acc(1'b0, 1'b1, 1'b1, 1'b1, 4'b0001);
    check("system_bus_lines_q", bus, 64'h0800_0012_3456_7890);
    give_verdict();
  end
  // Watchdog; the sequence needs about a hundred cycles
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule : tb_tlbst_top

// File: tlbst_access_check.sv
// Checks an access against matched page attributes
`timescale 1ns/1ps
module tlbst_access_check (
  input wire logic clk,
  input wire logic sys_rst,
  tlbst_chk_if.chk ci
);
  import tlbst_pkg::*;
  `include "tlbst_params.svh"

  // Fault flags are one-cycle pulses per access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ci.load_fault  <= 1'b0;
      ci.store_fault <= 1'b0;
      ci.mod_fault   <= 1'b0;
    end else begin
      ci.load_fault  <= ci.req & ~ci.lo.valid & ~ci.store;            // see RL10
      ci.store_fault <= ci.req & ~ci.lo.valid & ci.store;             // see RL10
      ci.mod_fault   <= ci.req & ci.lo.valid & ci.store & ~ci.lo.dirty; // see RL9
    end
  end

  // Address cycle word; refused accesses still load the word but never raise bus_valid
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ci.bus_valid <= 1'b0;
      ci.bus_word  <= `TLBST_RST_WORD;
    end else begin
      ci.bus_valid <= ci.req & ci.lo.valid & ~(ci.store & ~ci.lo.dirty);
      if (ci.req) begin
        ci.bus_word <= {24'h00_0000, ci.addr};
        if (ci.uncached) begin
          // Attribute lanes carry the page type
          ci.bus_word[`TLBST_BUS_UC_HI:`TLBST_BUS_UC_LO] <= ci.lo.uc; // see RL4
        end
      end
    end
  end

  property p_store_protect;  // see RL9
    @(posedge clk) disable iff (sys_rst)
    ci.req && ci.store && ci.lo.valid && !ci.lo.dirty |=> ci.mod_fault && !ci.bus_valid;
  endproperty
  a_store_protect: assert property (p_store_protect) // see RL9
    else $error("store to protected page not refused");

  property p_invalid_fault;  // see RL10
    @(posedge clk) disable iff (sys_rst)
    ci.req && !ci.lo.valid |=> (ci.load_fault ^ ci.store_fault) && !ci.bus_valid;
  endproperty
  a_invalid_fault: assert property (p_invalid_fault) // see RL10
    else $error("invalid page gave no single fault");

  property p_uc_drive;  // see RL4
    @(posedge clk) disable iff (sys_rst)
    ci.req && ci.uncached && ci.lo.valid && !ci.store
      |=> ci.bus_valid && ci.bus_word[59:58] == $past(ci.lo.uc);
  endproperty
  a_uc_drive: assert property (p_uc_drive) // see RL4
    else $error("uncached attribute missing on bus word");
endmodule : tlbst_access_check

// File: tlbst_chk_if.sv
// Carrier between the staging top and its access checker
`timescale 1ns/1ps
interface tlbst_chk_if;
  import tlbst_pkg::*;
  logic        req;          // Access presented this cycle
  logic        store;        // Access is a store
  logic        uncached;     // Uncached word or accelerated block
  logic [39:0] addr;         // Physical address
  tlbst_lo_s   lo;           // Matched page attributes
  logic        load_fault;   // Load to invalid page
  logic        store_fault;  // Store to invalid page
  logic        mod_fault;    // Store to protected page
  logic        bus_valid;    // Address cycle word valid
  logic [63:0] bus_word;     // Address cycle word
  modport top (output req, store, uncached, addr, lo,
               input load_fault, store_fault, mod_fault, bus_valid, bus_word);
  modport chk (input req, store, uncached, addr, lo,
               output load_fault, store_fault, mod_fault, bus_valid, bus_word);
endinterface : tlbst_chk_if

// File: tlbst_entry_mem.sv
// Translation entry storage with registered read data
`timescale 1ns/1ps
module tlbst_entry_mem #(
  parameter int WIDTH = 83,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output      logic [WIDTH-1:0] rdata_q
);
  // Refuse an array the index cannot reach
  if (DEPTH > (1 << AW)) begin : g_chk
    $error("tlbst_entry_mem: depth exceeds index range");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];  // Entry store

  // Write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge clk) begin
    rdata_q <= mem_q[raddr];
  end
endmodule : tlbst_entry_mem

// File: tlbst_far_model.sv
// Behavioural model of the miss logic on the far side of the staging block
`timescale 1ns/1ps
module tlbst_far_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [63:0] va,
  output      logic        miss_en,
  output      logic [63:0] miss_vaddr,
  output      logic [7:0]  miss_space_identifier
);
  // ********
  // Miss events
  // ********
  initial begin
    miss_en = 1'b0;
    miss_vaddr = '0;
    miss_space_identifier = '0;
  end
  // One-cycle event; address scrambled once released so stale values never help
  always @(posedge clk) begin
    miss_en <= go;
    miss_vaddr <= go ? va : ~miss_vaddr;
    miss_space_identifier <= go ? 8'h5A : ~miss_space_identifier;
  end
endmodule : tlbst_far_model

// File: tlbst_params.svh
// Offsets, field positions, reset values and sizes for the entry staging block
`ifndef TLBST_PARAMS_SVH
`define TLBST_PARAMS_SVH
// Register selects on the coprocessor move path
`define TLBST_SEL_EVEN_LO  5'h02
`define TLBST_SEL_ODD_LO   5'h03
`define TLBST_SEL_CONTEXT  5'h04
`define TLBST_SEL_PAGE_SIZE_MASK 5'h05
// Low-half entry word fields
`define TLBST_UC_HI     63
`define TLBST_UC_LO     62
`define TLBST_PFN_HI    33
`define TLBST_PFN_LO    6
`define TLBST_COH_HI    5
`define TLBST_COH_LO    3
`define TLBST_DIRTY_BIT 2
`define TLBST_VALID_BIT 1
`define TLBST_GLOBAL_BIT 0
// Pointer register fields
`define TLBST_BASE_LO   23
`define TLBST_PAIR_HI   22
`define TLBST_PAIR_LO   4
// Virtual address slices
`define TLBST_VA_PAIR_HI 31
`define TLBST_VA_PAIR_LO 13
`define TLBST_VPN2_HI    43
// Page-size mask field
`define TLBST_MASK_HI   24
`define TLBST_MASK_LO   13
// Attribute lanes on the system bus word
`define TLBST_BUS_UC_HI 59
`define TLBST_BUS_UC_LO 58
// Reset value and array size
`define TLBST_RST_WORD  64'h0000_0000_0000_0000
`define TLBST_ENTRIES   64
`endif

// File: tlbst_pkg.sv
// Types shared by the entry staging block
package tlbst_pkg;
  `include "tlbst_params.svh"

  // One low half as kept in staging and in the array
  typedef struct packed {
    logic [1:0]  uc;     // Uncached attribute
    logic [27:0] phys_frame_num;    // Frame number
    logic [2:0]  coh;    // Coherency attribute
    logic        dirty;  // Write enable for the page
    logic        valid;  // Translation present
  } tlbst_lo_s;

  // Full array entry as written and read back
  typedef struct packed {
    tlbst_lo_s   even;
    tlbst_lo_s   odd;
    logic        glob;   // Single global bit
    logic [11:0] mask;   // Page-size mask
  } tlbst_entry_s;

  // Entry read sequencing
  typedef enum logic [0:0] {TLBST_IDLE, TLBST_FETCH} tlbst_state_e;
endpackage : tlbst_pkg

// File: tlbst_top.sv
// Translation entry staging registers with entry array transfers
//
// How it works
// RL1 - Two identical low-half registers, even and odd.
// RL2 - Frame field covers physical bits 33:6.
// RL3 - Uncached bits 63:62 copied on entry write.
// RL4 - Uncached bits driven on bus 59:58.
// RL5 - 64-bit registers; narrow mode sees low 32.
// RL6 - Narrow loads sign-extend bit 31 upward.
// RL7 - Entry write stores frame masked, uncached not.
// RL8 - Uncached bits locked outside wide modes.
// RL9 - Clear dirty bit write-protects the page.
// RL10 - Clear valid bit raises load/store fault.
// RL11 - One global bit, AND of both bit 0.
// RL12 - Coherency field stored with each page.
// RL13 - Reserved bits read back as zero.
// RL14 - Miss loads pair field from address 31:13.
// RL15 - Table base is software-only, kept on miss.
// RL16 - Pointer indexes 16-byte pairs with 4K pages; the pointer steps 16 bytes per pair.
// RL17 - Mask register sources writes, receives reads.
// RL18 - Mask widens by two ones per step.
// RL19 - Software uses only the seven defined masks.
// RL20 - Index selects the array entry transferred.
// RL21 - Miss loads high-half page pair and space.
// RL22 - Software writes to the pair field ignored.
`timescale 1ns/1ps
`include "tlbst_params.svh"
module tlbst_top
  import tlbst_pkg::*;
#(
  parameter int ENTRIES = `TLBST_ENTRIES,
  parameter int IDX_W   = 6
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        cop_wr_en,
  input  wire logic        cop_rd_en,
  input  wire logic [4:0]  cop_sel,
  input  wire logic [63:0] cop_wdata,
  output      logic [63:0] cop_rdata_q,
  input  wire logic        kernel_mode,
  input  wire logic        ext64_en,
  input  wire logic [IDX_W-1:0] entry_index,
  input  wire logic        entry_write_en,
  input  wire logic        entry_read_en,
  output      logic        entry_read_done_q,
  input  wire logic [27:0] frame_suppress_reg,
  input  wire logic        miss_en,
  input  wire logic [63:0] miss_vaddr,
  input  wire logic [7:0]  miss_space_identifier,
  output      logic        hi_load_q,
  output      logic [30:0] hi_page_pair_q,
  output      logic [7:0]  hi_space_identifier_q,
  input  wire logic        acc_req,
  input  wire logic        acc_store,
  input  wire logic        acc_uncached,
  input  wire logic [39:0] acc_addr,
  input  wire tlbst_lo_s   acc_lo,
  output      logic        load_xlate_fault_q,
  output      logic        store_xlate_fault_q,
  output      logic        modify_fault_q,
  output      logic        bus_addr_valid_q,
  output      logic [63:0] system_bus_lines_q
);

  // ***************************************************************
  // Elaboration checks and declarations
  // ***************************************************************

  // Index width must reach every entry
  if (ENTRIES > (1 << IDX_W) || ENTRIES < 1) begin : g_chk
    $error("tlbst_top: entry count does not fit index width");
  end

  localparam int EW = $bits(tlbst_entry_s);  // Array word width

  tlbst_lo_s    even_q;        // Even page low half
  tlbst_lo_s    odd_q;         // Odd page low half
  logic         even_glob_q;   // Even bit 0
  logic         odd_glob_q;    // Odd bit 0
  logic [40:0]  base_q;        // Table base, pointer bits 63:23
  logic [18:0]  pair_q;        // Missed page pair
  logic [11:0]  mask_q;        // Page-size mask
  tlbst_state_e state_q;       // Entry read sequencer
  tlbst_entry_s wr_entry;      // Entry going to the array
  logic [EW-1:0] rd_word;      // Registered array data
  tlbst_entry_s rd_entry;      // Same, as a struct
  logic         wide;          // 64-bit operations available
  logic [63:0]  wval;          // Write data as the mode allows
  logic         rd_load;       // Array data lands in staging

  tlbst_chk_if  chk_if ();     // Link to the access checker

  // ***************************************************************
  // Helpers
  // ***************************************************************

  // Sign-extend the low word, as narrow modes see it
  function automatic logic [63:0] tlbst_narrow(input logic [63:0] v);
    return {{32{v[31]}}, v[31:0]};
  endfunction : tlbst_narrow

  // Pick the stored fields out of a low-half word
  function automatic tlbst_lo_s tlbst_to_lo(input logic [63:0] w);
    tlbst_lo_s r;
    r.uc    = w[`TLBST_UC_HI:`TLBST_UC_LO];
    r.phys_frame_num   = w[`TLBST_PFN_HI:`TLBST_PFN_LO];   // see RL2
    r.coh   = w[`TLBST_COH_HI:`TLBST_COH_LO];   // see RL12
    r.dirty = w[`TLBST_DIRTY_BIT];
    r.valid = w[`TLBST_VALID_BIT];
    return r;
  endfunction : tlbst_to_lo

  // Build a low-half word; gaps stay zero
  function automatic logic [63:0] tlbst_from_lo(input tlbst_lo_s l, input logic g);
    return {l.uc, 28'h000_0000, l.phys_frame_num, l.coh, l.dirty, l.valid, g}; // see RL13
  endfunction : tlbst_from_lo

  // ***************************************************************
  // Mode and write data
  // ***************************************************************

  // Kernel always has wide moves; elsewhere the extension decides
  assign wide    = kernel_mode | ext64_en;                       // see RL8
  // Narrow moves only carry the low word, sign-extended
  assign wval    = wide ? cop_wdata : tlbst_narrow(cop_wdata);   // see RL5 see RL6
  assign rd_load = (state_q == TLBST_FETCH);
  assign rd_entry = tlbst_entry_s'(rd_word);

  // ***************************************************************
  // Low-half entry registers
  // ***************************************************************

  // Even page; an array read landing here wins over a move
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      even_q      <= '0;
      even_glob_q <= 1'b0;
    end else if (rd_load) begin
      even_q      <= rd_entry.even;
      even_glob_q <= rd_entry.glob;                              // see RL11
    end else if (cop_wr_en && cop_sel == `TLBST_SEL_EVEN_LO) begin
      even_q      <= tlbst_to_lo(wval);                          // see RL1
      // Uncached bits cannot be set from narrow modes
      if (!wide) begin
        even_q.uc <= even_q.uc;                                  // see RL8
      end
      even_glob_q <= wval[`TLBST_GLOBAL_BIT];
    end
  end

  // Odd page, same format and same precedence
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      odd_q      <= '0;
      odd_glob_q <= 1'b0;
    end else if (rd_load) begin
      odd_q      <= rd_entry.odd;
      odd_glob_q <= rd_entry.glob;                               // see RL11
    end else if (cop_wr_en && cop_sel == `TLBST_SEL_ODD_LO) begin
      odd_q      <= tlbst_to_lo(wval);                           // see RL1
      if (!wide) begin
        odd_q.uc <= odd_q.uc;                                    // see RL8
      end
      odd_glob_q <= wval[`TLBST_GLOBAL_BIT];
    end
  end

  // ***************************************************************
  // Page-table pointer
  // ***************************************************************

  // Base belongs to software alone; misses never touch it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_q <= '0;
    end else if (cop_wr_en && cop_sel == `TLBST_SEL_CONTEXT) begin
      base_q <= wval[63:`TLBST_BASE_LO];                         // see RL15
    end
  end

  // Pair field is filled only by misses, so it shows the latest one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pair_q <= '0;
    end else if (miss_en) begin
      pair_q <= miss_vaddr[`TLBST_VA_PAIR_HI:`TLBST_VA_PAIR_LO]; // see RL14 see RL22
    end
  end

  // High-half load request with page pair and space
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hi_load_q             <= 1'b0;
      hi_page_pair_q        <= '0;
      hi_space_identifier_q <= '0;
    end else begin
      hi_load_q <= miss_en;                                      // see RL21
      if (miss_en) begin
        hi_page_pair_q        <= miss_vaddr[`TLBST_VPN2_HI:`TLBST_VA_PAIR_LO];
        hi_space_identifier_q <= miss_space_identifier;
      end
    end
  end

  // ***************************************************************
  // Page-size mask
  // ***************************************************************

  // Only the 12 mask bits are kept; undefined patterns are not
  // repaired, the array just sees them as written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= '0;
    end else if (rd_load) begin
      mask_q <= rd_entry.mask;                                   // see RL17
    end else if (cop_wr_en && cop_sel == `TLBST_SEL_PAGE_SIZE_MASK) begin
      mask_q <= wval[`TLBST_MASK_HI:`TLBST_MASK_LO];             // see RL18
    end
  end

  // ***************************************************************
  // Register read
  // ***************************************************************

  // Read data one cycle after the strobe; unmapped selects give zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cop_rdata_q <= `TLBST_RST_WORD;
    end else if (cop_rd_en) begin
      if (cop_sel == `TLBST_SEL_EVEN_LO) begin
        cop_rdata_q <= wide ? tlbst_from_lo(even_q, even_glob_q)
                            : tlbst_narrow(tlbst_from_lo(even_q, even_glob_q)); // see RL5
      end else if (cop_sel == `TLBST_SEL_ODD_LO) begin
        cop_rdata_q <= wide ? tlbst_from_lo(odd_q, odd_glob_q)
                            : tlbst_narrow(tlbst_from_lo(odd_q, odd_glob_q));
      end else if (cop_sel == `TLBST_SEL_CONTEXT) begin
        // Low four bits zero: a direct 16-byte pair pointer
        cop_rdata_q <= wide ? {base_q, pair_q, 4'h0}
                            : tlbst_narrow({base_q, pair_q, 4'h0}); // see RL16
      end else if (cop_sel == `TLBST_SEL_PAGE_SIZE_MASK) begin
        cop_rdata_q <= {39'h00_0000_0000, mask_q, 13'h0000};     // see RL13
      end else begin
        cop_rdata_q <= `TLBST_RST_WORD;
      end
    end
  end

  // ***************************************************************
  // Entry array transfers
  // ***************************************************************

  // Frame bits can be suppressed, uncached bits always go in
  always_comb begin
    wr_entry          = '0;
    wr_entry.even     = even_q;                                  // see RL3
    wr_entry.odd      = odd_q;
    wr_entry.even.phys_frame_num = even_q.phys_frame_num & ~frame_suppress_reg;        // see RL7
    wr_entry.odd.phys_frame_num  = odd_q.phys_frame_num & ~frame_suppress_reg;
    wr_entry.glob     = even_glob_q & odd_glob_q;                // see RL11
    wr_entry.mask     = mask_q;                                  // see RL17
  end

  tlbst_entry_mem #(
    .WIDTH (EW),
    .DEPTH (ENTRIES),
    .AW    (IDX_W)
  ) u_mem (
    .clk     (clk),
    .we      (entry_write_en),
    .waddr   (entry_index),                                      // see RL20
    .wdata   (wr_entry),
    .raddr   (entry_index),
    .rdata_q (rd_word)
  );

  // Read takes a cycle in the array, then lands in staging
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= TLBST_IDLE;
    end else begin
      case (state_q)
        TLBST_IDLE:  state_q <= entry_read_en ? TLBST_FETCH : TLBST_IDLE;
        TLBST_FETCH: state_q <= TLBST_IDLE;
        default:     state_q <= TLBST_IDLE;
      endcase
    end
  end

  // Done pulses in the cycle the staging registers show the entry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      entry_read_done_q <= 1'b0;
    end else begin
      entry_read_done_q <= rd_load;
    end
  end

  // ***************************************************************
  // Access checking
  // ***************************************************************

  assign chk_if.req      = acc_req;
  assign chk_if.store    = acc_store;
  assign chk_if.uncached = acc_uncached;
  assign chk_if.addr     = acc_addr;
  assign chk_if.lo       = acc_lo;

  tlbst_access_check u_chk (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ci      (chk_if)
  );

  // Checker outputs are already flops
  assign load_xlate_fault_q  = chk_if.load_fault;
  assign store_xlate_fault_q = chk_if.store_fault;
  assign modify_fault_q      = chk_if.mod_fault;
  assign bus_addr_valid_q    = chk_if.bus_valid;
  assign system_bus_lines_q  = chk_if.bus_word;

  // ***************************************************************
  // Assertions
  // ***************************************************************

  property p_pair_on_miss;  // see RL14
    @(posedge clk) disable iff (sys_rst)
    miss_en |=> pair_q == $past(miss_vaddr[31:13]);
  endproperty
  a_pair_on_miss: assert property (p_pair_on_miss) // see RL14
    else $error("pair field not loaded from miss");

  property p_pair_sw_ignored;  // see RL22
    @(posedge clk) disable iff (sys_rst)
    !miss_en && cop_wr_en && cop_sel == 5'h04 |=> $stable(pair_q);
  endproperty
  a_pair_sw_ignored: assert property (p_pair_sw_ignored) // see RL22
    else $error("software changed pair field");

  property p_base_kept;  // see RL15
    @(posedge clk) disable iff (sys_rst)
    miss_en && !cop_wr_en |=> $stable(base_q);
  endproperty
  a_base_kept: assert property (p_base_kept) // see RL15
    else $error("miss changed table base");

  property p_uc_locked;  // see RL8
    @(posedge clk) disable iff (sys_rst)
    cop_wr_en && !wide && !rd_load && cop_sel == 5'h02 |=> $stable(even_q.uc);
  endproperty
  a_uc_locked: assert property (p_uc_locked) // see RL8
    else $error("uncached bits set from narrow mode");

  property p_narrow_read;  // see RL6
    @(posedge clk) disable iff (sys_rst)
    cop_rd_en && !wide |=> cop_rdata_q[63:32] == {32{cop_rdata_q[31]}};
  endproperty
  a_narrow_read: assert property (p_narrow_read) // see RL6
    else $error("narrow read not sign-extended");

  property p_mask_reserved;  // see RL13
    @(posedge clk) disable iff (sys_rst)
    cop_rd_en && cop_sel == 5'h05 |=> cop_rdata_q[63:25] == '0 && cop_rdata_q[12:0] == '0;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) // see RL13
    else $error("mask reserved bits not zero");

  property p_read_done;  // see RL20
    @(posedge clk) disable iff (sys_rst)
    entry_read_en && state_q == TLBST_IDLE |=> ##1 entry_read_done_q && mask_q == $past(rd_entry.mask);
  endproperty
  a_read_done: assert property (p_read_done) // see RL20
    else $error("entry read did not land in two cycles");

  property p_ptr_aligned;  // see RL16
    @(posedge clk) disable iff (sys_rst)
    cop_rd_en && cop_sel == 5'h04 |=> cop_rdata_q[3:0] == 4'h0;
  endproperty
  a_ptr_aligned: assert property (p_ptr_aligned) // see RL16
    else $error("pointer low bits not zero");
endmodule : tlbst_top
